//--- cfg_responder.sv
// Purpose: Device end; decodes config messages, answers with tokens
// Assumes: Requester keeps the message order and framing
// Notes: One small register bank stands in for all three addressed banks
//
// Contract
// - Requests carry 24-bit reply channel-end
// - Low reply byte all ones: no reply to a write; reads are still answered
// - Multi-byte fields travel MSB first
// - PS resource id is reg shl 8 or 0x0b
// - Write: 192, reply, reg, data, 1
// - Write answer 3,1 success, 4,1 failure
// - Read: 193, reply, reg, 1
// - Read answer 3,data,1 or 4,1
// - Tile bank at tile id plus C20C
// - Node bank at node id plus C30C
// - Peripheral bank at node, periph, 02
`timescale 1ns/10ps
`default_nettype none
module cfg_responder
  import cfg_msg_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  cfg_link_if.device LINK,
  input wire logic [15:0] TILE_ID,
  input wire logic [15:0] NODE_ID,
  output logic BUSY
);
  typedef enum {
    S_CMD, S_REPLY, S_REG, S_DATA, S_END, S_DRAIN,
    S_ANS, S_RDATA, S_CLOSE
  } state_type;

  state_type state;
  logic is_read;
  logic bad;
  logic [2:0] cnt;
  logic [23:0] reply;
  logic [15:0] regnum;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ok;
  logic [31:0] bank [NUM_REGS];
  logic ready_q;
  logic rv_q;
  logic rc_q;
  logic [7:0] rb_q;

  // ****************************************************
  // Decode
  // ****************************************************
  wire take = LINK.req_valid && ready_q;
  wire tok = LINK.req_ctrl;
  wire [7:0] b = LINK.req_byte;
  wire hit_tile = LINK.req_dest == {TILE_ID, TILE_CODE};
  wire hit_node = LINK.req_dest == {NODE_ID, NODE_CODE};
  wire hit_per = LINK.req_dest[31:16] == NODE_ID &&
    LINK.req_dest[7:0] == PERIPH_CODE;
  wire hit_any = hit_tile || hit_node || hit_per;
  wire reg_ok = regnum < 16'(NUM_REGS);
  wire [3:0] idx = regnum[3:0];
  wire silent = reply[7:0] == NO_REPLY_LOW;
  wire rsp_take = rv_q && LINK.rsp_ready;

  assign LINK.req_ready = ready_q;
  assign LINK.rsp_valid = rv_q;
  assign LINK.rsp_ctrl = rc_q;
  assign LINK.rsp_byte = rb_q;
  assign LINK.rsp_dest = reply;

  // ****************************************************
  // Message engine
  // ****************************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= S_CMD;
      is_read <= 1'b0;
      bad <= 1'b0;
      cnt <= 3'h0;
      reply <= 24'h0;
      regnum <= 16'h0;
      wdata <= 32'h0;
      rdata <= 32'h0;
      ok <= 1'b0;
      ready_q <= 1'b1;
      rv_q <= 1'b0;
      rc_q <= 1'b0;
      rb_q <= 8'h0;
      BUSY <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) bank[i] <= 32'h0;
    end else begin
      case (state)
        S_CMD: if (take) begin
          cnt <= 3'h0;
          is_read <= b == TOK_READ;
          // Unknown opener or wrong address: discard up to closing token
          bad <= !tok || !hit_any ||
            (b != TOK_WRITE && b != TOK_READ);
          state <= S_REPLY;
          BUSY <= 1'b1;
        end
        S_REPLY: if (take) begin
          reply <= {reply[15:0], b};
          if (tok) bad <= 1'b1;
          cnt <= cnt + 3'h1;
          if (cnt == 3'(REPLY_BYTES - 1)) begin
            cnt <= 3'h0;
            state <= S_REG;
          end
        end
        S_REG: if (take) begin
          regnum <= {regnum[7:0], b};
          if (tok) bad <= 1'b1;
          cnt <= cnt + 3'h1;
          if (cnt == 3'(REGNUM_BYTES - 1)) begin
            cnt <= 3'h0;
            state <= is_read ? S_END : S_DATA;
          end
        end
        S_DATA: if (take) begin
          wdata <= {wdata[23:0], b};
          if (tok) bad <= 1'b1;
          cnt <= cnt + 3'h1;
          if (cnt == 3'(DATA_BYTES - 1)) state <= S_END;
        end
        S_END: if (take) begin
          if (tok && b == TOK_END) begin
            // Nothing acts before the closing token
            ready_q <= 1'b0;
            ok <= !bad && reg_ok;
            if (!bad && reg_ok && !is_read)
              bank[idx] <= wdata;
            rdata <= bank[idx];
            state <= S_ANS;
          end else begin
            bad <= 1'b1;
            if (!tok) state <= S_DRAIN;
          end
        end
        S_DRAIN: if (take && tok && b == TOK_END) begin
          ready_q <= 1'b0;
          ok <= 1'b0;
          state <= S_ANS;
        end
        S_ANS: if (!rv_q) begin
          if (silent && !is_read) begin
            // Suppressed write reply
            ready_q <= 1'b1;
            BUSY <= 1'b0;
            state <= S_CMD;
          end else begin
            rv_q <= 1'b1;
            rc_q <= 1'b1;
            rb_q <= ok ? TOK_ACK : TOK_NACK;
            cnt <= 3'h0;
            state <= (ok && is_read) ? S_RDATA : S_CLOSE;
          end
        end
        S_RDATA: if (rsp_take) begin
          rc_q <= 1'b0;
          rb_q <= rdata[31:24];
          rdata <= {rdata[23:0], 8'h0};
          cnt <= cnt + 3'h1;
          if (cnt == 3'(DATA_BYTES - 1)) state <= S_CLOSE;
        end
        S_CLOSE: if (rsp_take) begin
          if (rc_q && rb_q == TOK_END) begin
            rv_q <= 1'b0;
            ready_q <= 1'b1;
            BUSY <= 1'b0;
            state <= S_CMD;
          end else begin
            rc_q <= 1'b1;
            rb_q <= TOK_END;
          end
        end
        default: state <= S_CMD;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- cfg_msg_pkg.sv
// Purpose: Shared constants for the configuration message link
// Assumes: Byte-wide token link, one token per valid/ready beat
// Notes: Destination words identify tile, node and peripheral banks
package cfg_msg_pkg;
  localparam logic [7:0] TOK_WRITE = 8'hc0;
  localparam logic [7:0] TOK_READ = 8'hc1;
  localparam logic [7:0] TOK_END = 8'h01;
  localparam logic [7:0] TOK_ACK = 8'h03;
  localparam logic [7:0] TOK_NACK = 8'h04;
  localparam logic [7:0] NO_REPLY_LOW = 8'hff;
  localparam logic [15:0] TILE_CODE = 16'hc20c;
  localparam logic [15:0] NODE_CODE = 16'hc30c;
  localparam logic [7:0] PERIPH_CODE = 8'h02;
  localparam logic [7:0] PS_RES_TYPE = 8'h0b;
  localparam int PS_SHIFT = 8;
  localparam int REPLY_BYTES = 3;
  localparam int REGNUM_BYTES = 2;
  localparam int DATA_BYTES = 4;
  localparam int NUM_REGS = 16;
endpackage

//--- cfg_link_if.sv
// Purpose: Token link between requester and configuration responder
// Assumes: Single clock, valid/ready handshake per token
// Notes: ctrl marks a control token rather than a data byte
`timescale 1ns/10ps
`default_nettype none
interface cfg_link_if;
  logic req_valid;
  logic req_ready;
  logic req_ctrl;
  logic [7:0] req_byte;
  logic [31:0] req_dest;
  logic rsp_valid;
  logic rsp_ready;
  logic rsp_ctrl;
  logic [7:0] rsp_byte;
  logic [23:0] rsp_dest;
  modport device (
    input req_valid, req_ctrl, req_byte, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_byte, rsp_dest
  );
  modport requester (
    output req_valid, req_ctrl, req_byte, req_dest, rsp_ready,
    input req_ready, rsp_valid, rsp_ctrl, rsp_byte, rsp_dest
  );
endinterface
`default_nettype wire

//--- cfg_requester.sv
// Purpose: Requester end; frames config reads and writes as tokens
// Assumes: One access outstanding at a time
// Notes: DONE pulses when the answer closes or a silent write ends
`timescale 1ns/10ps
`default_nettype none
module cfg_requester
  import cfg_msg_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  cfg_link_if.requester LINK,
  input wire logic START,
  input wire logic READ,
  input wire logic [31:0] DEST,
  input wire logic [23:0] REPLY_ID,
  input wire logic [15:0] REG_NUM,
  input wire logic [31:0] WDATA,
  output logic READY,
  output logic DONE,
  output logic OK,
  output logic [31:0] RDATA
);
  typedef enum {Q_IDLE, Q_SEND, Q_WAIT} state_type;

  state_type state;
  logic [79:0] shreg;
  logic [3:0] left;
  logic rd;
  logic silent;
  logic v_q;
  logic c_q;
  logic [7:0] b_q;
  logic [31:0] dest;

  wire sent = v_q && LINK.req_ready;
  wire got = LINK.rsp_valid;
  assign LINK.req_valid = v_q;
  assign LINK.req_ctrl = c_q;
  assign LINK.req_byte = b_q;
  assign LINK.req_dest = dest;
  assign LINK.rsp_ready = state == Q_WAIT;
  // Count of bytes and tokens after the opener, closing token included
  wire [3:0] body = READ ? 4'h6 : 4'ha;

  // Resource id for processor-status access, kept for users of this end
  function automatic logic [31:0] ps_res(input logic [15:0] r);
    ps_res = ({16'h0, r} << PS_SHIFT) | {24'h0, PS_RES_TYPE};
  endfunction

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= Q_IDLE;
      shreg <= 80'h0;
      left <= 4'h0;
      rd <= 1'b0;
      silent <= 1'b0;
      v_q <= 1'b0;
      c_q <= 1'b0;
      b_q <= 8'h0;
      dest <= 32'h0;
      READY <= 1'b1;
      DONE <= 1'b0;
      OK <= 1'b0;
      RDATA <= 32'h0;
    end else begin
      DONE <= 1'b0;
      case (state)
        Q_IDLE: if (START) begin
          READY <= 1'b0;
          rd <= READ;
          silent <= !READ && REPLY_ID[7:0] == NO_REPLY_LOW;
          dest <= DEST;
          // MSB-first payload queue, closing token last
          shreg <= READ ? {REPLY_ID, REG_NUM, TOK_END, 32'h0} :
            {REPLY_ID, REG_NUM, WDATA, TOK_END};
          v_q <= 1'b1;
          c_q <= 1'b1;
          b_q <= READ ? TOK_READ : TOK_WRITE;
          left <= body;
          state <= Q_SEND;
        end
        Q_SEND: if (sent) begin
          if (left == 4'h0) begin
            v_q <= 1'b0;
            if (silent) begin
              OK <= 1'b1;
              DONE <= 1'b1;
              READY <= 1'b1;
              state <= Q_IDLE;
            end else begin
              state <= Q_WAIT;
            end
          end else begin
            b_q <= shreg[79:72];
            c_q <= left == 4'h1;
            shreg <= {shreg[71:0], 8'h0};
            left <= left - 4'h1;
          end
        end
        Q_WAIT: if (got) begin
          if (LINK.rsp_ctrl) begin
            if (LINK.rsp_byte == TOK_ACK) OK <= 1'b1;
            if (LINK.rsp_byte == TOK_NACK) OK <= 1'b0;
            if (LINK.rsp_byte == TOK_END) begin
              DONE <= 1'b1;
              READY <= 1'b1;
              state <= Q_IDLE;
            end
          end else if (rd) begin
            RDATA <= {RDATA[23:0], LINK.rsp_byte};
          end
        end
        default: state <= Q_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- cfg_link_checker.sv
// Purpose: Assertions on the token link between the two ends
// Assumes: One request at a time; beats counted from the opener
// Notes: Reply id is rebuilt from the wire to check answer routing
`timescale 1ns/10ps
`default_nettype none
module cfg_link_checker
  import cfg_msg_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_ctrl,
  input wire logic [7:0] req_byte,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_byte,
  input wire logic [23:0] rsp_dest
);
  // ************
  // Framing tracker
  // ************
  logic [3:0] cnt;
  logic wr;
  logic [23:0] rid;
  wire take = req_valid && req_ready;
  wire fin = take && req_ctrl && req_byte == TOK_END;
  wire ack = rsp_valid && rsp_ready && rsp_ctrl && rsp_byte == TOK_ACK;
  wire nak = rsp_valid && rsp_ready && rsp_ctrl && rsp_byte == TOK_NACK;
  wire silent = rid[7:0] == NO_REPLY_LOW;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt <= 4'h0;
      wr <= 1'b0;
      rid <= 24'h0;
    end else if (take) begin
      cnt <= fin ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h0)
        wr <= req_byte == TOK_WRITE;
      if (cnt != 4'h0 && cnt < 4'h4)
        rid <= {rid[15:0], req_byte};
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  opener_a: assert property (
    req_valid && cnt == 4'h0 |-> req_ctrl
      && (req_byte == TOK_WRITE || req_byte == TOK_READ))
    else $error("bad request opener");
  framing_a: assert property (
    req_valid && cnt != 4'h0 |-> req_ctrl == (cnt == (wr ? 4'ha : 4'h6)))
    else $error("control token out of place");
  answer_lag_a: assert property (
    fin && !silent |-> ##2 rsp_valid && rsp_ctrl)
    else $error("answer late");
  silent_a: assert property (
    fin && wr && silent |=> !rsp_valid [*6])
    else $error("answer to silent write");
  first_tok_a: assert property (
    $rose(rsp_valid) |-> rsp_ctrl
      && (rsp_byte == TOK_ACK || rsp_byte == TOK_NACK))
    else $error("bad answer opener");
  close_a: assert property (
    nak || ack && wr |-> ##[1:3] rsp_valid && rsp_ctrl && rsp_byte == TOK_END)
    else $error("status not closed");
  read_data_a: assert property (
    ack && !wr |-> ##[1:3] rsp_valid && !rsp_ctrl)
    else $error("read success without data");
  route_a: assert property (
    rsp_valid |-> rsp_dest == rid && !req_ready)
    else $error("answer misrouted");
endmodule
`default_nettype wire

//--- testbench.sv
// Purpose: Drives both ends through reads, writes and refusals
// Assumes: Requester and responder share one link and one clock
// Notes: Wire order is checked from bytes captured on the link
`timescale 1ns/10ps
`default_nettype none
module testbench
  import cfg_msg_pkg::*;
;
  logic core_clk, rst, start, read, ready, done, ok, busy;
  logic [31:0] dest, wdata, rdata, val, bank;
  logic [23:0] reply_id;
  logic [15:0] reg_num, rn, tile_id, node_id;
  logic [71:0] req_bits;
  logic [31:0] rsp_bits;
  int miscompares, check_count;
  cfg_link_if link ();
  cfg_responder u_cfg_responder (.CORE_CLK(core_clk), .RST(rst),
    .LINK(link), .TILE_ID(tile_id), .NODE_ID(node_id), .BUSY(busy));
  cfg_requester u_cfg_requester (.CORE_CLK(core_clk), .RST(rst),
    .LINK(link), .START(start), .READ(read), .DEST(dest),
    .REPLY_ID(reply_id), .REG_NUM(reg_num), .WDATA(wdata),
    .READY(ready), .DONE(done), .OK(ok), .RDATA(rdata));
  cfg_link_checker u_checker (.CORE_CLK(core_clk), .RST(rst),
    .req_valid(link.req_valid), .req_ready(link.req_ready),
    .req_ctrl(link.req_ctrl), .req_byte(link.req_byte),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
    .rsp_ctrl(link.rsp_ctrl), .rsp_byte(link.rsp_byte),
    .rsp_dest(link.rsp_dest));
  // ************
  // Wire capture and tasks
  // ************
  always @(posedge core_clk) begin
    if (link.req_valid && link.req_ready && !link.req_ctrl)
      req_bits <= {req_bits[63:0], link.req_byte};
    if (link.rsp_valid && link.rsp_ready && !link.rsp_ctrl)
      rsp_bits <= {rsp_bits[23:0], link.rsp_byte};
  end
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic wrap_up();
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic compare(input logic [71:0] got, input logic [71:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic rd, input logic [31:0] d,
      input logic [15:0] r, input logic [23:0] rid);
    int n;
    logic seen;
    seen = 1'b0;
    for (n = 0; ready !== 1'b1 && n < 400; n++)
      @(posedge core_clk) #1;
    if (n == 400) begin
      compare(72'(ready), 72'h1);
      wrap_up();
    end
    {read, dest, reg_num, reply_id, wdata} = {rd, d, r, rid, val};
    start = 1'b1;
    @(posedge core_clk) #1;
    start = 1'b0;
    // Bounded so a lost answer ends the run instead of hanging it
    for (n = 0; done !== 1'b1 && n < 400; n++) begin
      @(posedge core_clk) #1;
      seen = seen | busy;
    end
    if (n == 400) begin
      compare(72'(done), 72'h1);
      wrap_up();
    end
    // The responder must show itself busy while a message is handled
    compare(72'(seen), 72'h1);
  endtask
  initial begin
    rst = 1'b1;
    {start, read, dest, wdata, reply_id, reg_num, val} = '0;
    tile_id = 16'h0012;
    node_id = 16'h0034;
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    compare(72'(u_cfg_requester.ps_res(16'h0005)), 72'h50b);
    compare(72'(u_cfg_requester.ps_res(16'h0012)), 72'h120b);
    for (int i = 0; i < 3; i++) begin
      val = 32'h1a2b_3c4d + 32'(i);
      rn = 16'h000f - 16'(5 * i);
      bank = i == 0 ? {tile_id, TILE_CODE} : i == 1 ? {node_id, NODE_CODE}
        : {node_id, 8'h5a, PERIPH_CODE};
      access(1'b0, bank, rn, 24'h000510);
      compare(72'(ok), 72'h1);
      compare(req_bits, {24'h000510, rn, val});
      access(1'b1, bank, rn, 24'h000511);
      compare(72'(ok), 72'h1);
      compare(72'(rdata), 72'(val));
      compare(72'(rsp_bits), 72'(val));
      compare(72'(req_bits[39:0]), 72'({24'h000511, rn}));
    end
    val = 32'h5566_7788;
    access(1'b0, {tile_id, TILE_CODE}, 16'h0006, 24'h0005ff);
    access(1'b1, {tile_id, TILE_CODE}, 16'h0006, 24'h000512);
    compare(72'(rdata), 72'(val));
    access(1'b0, {tile_id, TILE_CODE}, 16'h0010, 24'h000513);
    compare(72'(ok), 72'h0);
    for (int i = 0; i < 4; i++) begin
      bank = i == 0 ? {tile_id, TILE_CODE} : i == 1 ? {16'h0099, TILE_CODE}
        : i == 2 ? {node_id, 16'hc40c} : {node_id, 8'h5a, 8'h03};
      access(1'b1, bank, i == 0 ? 16'h0010 : 16'h0001, 24'h000514);
      compare(72'(ok), 72'h0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
